// [design/strap_cfg_pkg.sv]
// Shared constants for the power-up strap and configuration loader
package strap_cfg_pkg;

	// Clock and timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int STRAP_HOLD_MS = 50;
	localparam int STRAP_HOLD_CYCLES = (STRAP_HOLD_MS * 1_000_000 + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;

	// Configuration space
	localparam int CFG_DEPTH = 253;
	localparam int CFG_WIDTH = 8;
	localparam logic [7:0] CFG_LAST_ADDR = 8'h00_FC;
	localparam logic [7:0] CFG_END_ADDR = 8'h00_FD;

	// Register offsets
	localparam logic [7:0] REF_TYPE_ADDR = 8'h00_0A;
	localparam logic [7:0] DIFF_EN_ADDR = 8'h00_20;
	localparam logic [7:0] CMOS_EN_ADDR = 8'h00_21;
	localparam logic [7:0] GPIO_OUT_ADDR = 8'h00_30;
	localparam logic [7:0] GPIO_OE_ADDR = 8'h00_31;
	localparam logic [7:0] STATUS_ADDR = 8'h00_40;

	// Reset values
	localparam logic [7:0] REF_TYPE_RESET = 8'h00_01;
	localparam logic [7:0] OTHER_RESET = 8'h00_00;

	// Field positions
	localparam int REF_ZERO_DIFF_BIT = 0;
	localparam int REF_ONE_DIFF_BIT = 1;
	localparam int STAT_OPTS_LSB = 2;
	localparam int STAT_OTP_BIT = 5;
	localparam int STAT_MCLK_OK_BIT = 6;
	localparam int STAT_DONE_BIT = 7;

	// Strap pin positions
	localparam int GPIO_WIDTH = 6;
	localparam int MCLK_STRAP_LSB = 0;
	localparam int TEST_STRAP_BIT = 2;
	localparam int OPT_STRAP_LSB = 3;

	// Master clock strap codes
	localparam logic [1:0] MCLK_24M576 = 2'h3;

	typedef enum logic [1:0] {
		ST_RESET,
		ST_HOLD,
		ST_LOAD,
		ST_RUN
	} loader_state_e;

endpackage

// [design/pin_sync3.sv]
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module pin_sync3 #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// Pins and filtered level
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] level_out
);

	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;
	logic [WIDTH-1:0] next_level;

	always_comb begin
		for (int i = 0; i < WIDTH; i++) begin
			next_level[i] = (stage2[i] == stage3[i]) ? stage3[i] : level_out[i];
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			stage1 <= INIT;
			stage2 <= INIT;
			stage3 <= INIT;
			level_out <= INIT;
		end else begin
			stage1 <= pin_in;
			stage2 <= stage1;
			stage3 <= stage2;
			level_out <= next_level;
		end
	end

endmodule

// [design/powerup_strap_config_loader.sv]
// Power-up reset, strap capture and configuration loader
`timescale 1ns/100ps
// What this block does
// - Ref zero differential, ref one single-ended default
// - Master clock chosen from pins after release
// - Strap value 3 means 24.576 MHz
// - Default configuration runs after reset release
// - Pins 0,1,3,4,5 captured as straps
// - Clock outputs disabled until software, the OTP image or the pin 2 test strap enables
// - Pin 2 high enables first differential output unless pin 2 is set as an output
// - Configuration space is 253 bytes
// - Filled from defaults, OTP or host
// - Host may rewrite registers while running
// - Stored OTP image replaces built-in defaults
module powerup_strap_config_loader #(
	parameter int HOLD_CYCLES = strap_cfg_pkg::STRAP_HOLD_CYCLES
) (
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic sys_rst_in,
	// Power-on reset pin
	input wire logic power_on_rst_n_in,
	// General-purpose pins
	input wire logic [5:0] gpio_in,
	output logic [5:0] gpio_out,
	output logic [5:0] gpio_oe_out,
	// OTP image port
	input wire logic otp_custom_in,
	input wire logic [7:0] otp_data_in,
	output logic [7:0] otp_addr_out,
	// Host register port
	input wire logic host_req_in,
	input wire logic host_we_in,
	input wire logic [7:0] host_addr_in,
	input wire logic [7:0] host_wdata_in,
	output logic host_ack_out,
	output logic [7:0] host_rdata_out,
	output logic host_busy_out,
	// Device control and status
	output logic device_rst_out,
	output logic config_done_out,
	output logic [1:0] mclk_sel_out,
	output logic mclk_24m576_out,
	output logic mclk_reserved_out,
	output logic [2:0] strap_opts_out,
	output logic ref_zero_diff_out,
	output logic ref_one_diff_out,
	output logic [3:0] diff_out_en_out,
	output logic [1:0] cmos_out_en_out
);

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers

	logic por_level;
	logic [5:0] gpio_level;

	pin_sync3 #(.WIDTH(1), .INIT(1'b0)) u_por_sync (
		.clk_in(sys_clk_in),
		.rst_in(sys_rst_in),
		.pin_in(power_on_rst_n_in),
		.level_out(por_level)
	);

	pin_sync3 #(.WIDTH(6), .INIT(6'h00)) u_gpio_sync (
		.clk_in(sys_clk_in),
		.rst_in(sys_rst_in),
		.pin_in(gpio_in),
		.level_out(gpio_level)
	);

	////////////////////////////////////////////////////////////////////////////
	// Configuration space

	logic [7:0] cfg_mem [strap_cfg_pkg::CFG_DEPTH];
	logic mem_we;
	logic [7:0] mem_addr;
	logic [7:0] mem_wdata;

	always_ff @(posedge sys_clk_in) begin
		if (mem_we) begin
			cfg_mem[mem_addr] <= mem_wdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Sequencer state

	strap_cfg_pkg::loader_state_e state;
	strap_cfg_pkg::loader_state_e next_state;
	logic [31:0] hold_cnt;
	logic [31:0] next_hold_cnt;
	logic [7:0] load_addr;
	logic [7:0] next_load_addr;
	logic load_issued;
	logic next_load_issued;
	logic otp_custom;
	logic next_otp_custom;
	logic [7:0] next_otp_addr;
	logic [1:0] next_mclk_sel;
	logic [2:0] next_strap_opts;
	logic [7:0] status_val;

	assign status_val = {config_done_out, mclk_24m576_out, otp_custom, strap_opts_out,
		mclk_sel_out};

	always_comb begin
		next_state = state;
		next_hold_cnt = hold_cnt;
		next_load_addr = load_addr;
		next_load_issued = 1'b0;
		next_otp_custom = otp_custom;
		next_otp_addr = otp_addr_out;
		next_mclk_sel = mclk_sel_out;
		next_strap_opts = strap_opts_out;
		mem_we = 1'b0;
		mem_addr = 8'h00_00;
		mem_wdata = 8'h00_00;
		case (state)
			strap_cfg_pkg::ST_RESET: begin
				next_hold_cnt = 32'h0000_0000;
				if (por_level) begin
					next_state = strap_cfg_pkg::ST_HOLD;
				end
			end
			strap_cfg_pkg::ST_HOLD: begin
				if (hold_cnt == 32'(HOLD_CYCLES - 1)) begin
					// Straps sampled once the hold window closes
					next_mclk_sel = gpio_level[strap_cfg_pkg::MCLK_STRAP_LSB +: 2];
					next_strap_opts = gpio_level[strap_cfg_pkg::OPT_STRAP_LSB +: 3];
					next_otp_custom = otp_custom_in;
					next_load_addr = 8'h00_00;
					next_state = strap_cfg_pkg::ST_LOAD;
				end else begin
					next_hold_cnt = hold_cnt + 32'h0000_0001;
				end
			end
			strap_cfg_pkg::ST_LOAD: begin
				if (load_addr != strap_cfg_pkg::CFG_END_ADDR) begin
					next_otp_addr = load_addr;
					next_load_issued = 1'b1;
					next_load_addr = load_addr + 8'h00_01;
				end else if (!load_issued) begin
					next_state = strap_cfg_pkg::ST_RUN;
				end
				// OTP data taken in the same cycle its address is on otp_addr_out
				if (load_issued) begin
					mem_we = 1'b1;
					mem_addr = otp_addr_out;
					if (otp_custom) begin
						mem_wdata = otp_data_in;
					end else if (otp_addr_out == strap_cfg_pkg::REF_TYPE_ADDR) begin
						mem_wdata = strap_cfg_pkg::REF_TYPE_RESET;
					end else begin
						mem_wdata = strap_cfg_pkg::OTHER_RESET;
					end
				end
			end
			strap_cfg_pkg::ST_RUN: begin
				if (host_req_in && host_we_in
					&& host_addr_in <= strap_cfg_pkg::CFG_LAST_ADDR
					&& host_addr_in != strap_cfg_pkg::STATUS_ADDR) begin
					mem_we = 1'b1;
					mem_addr = host_addr_in;
					mem_wdata = host_wdata_in;
				end
			end
			default: begin
				next_state = strap_cfg_pkg::ST_RESET;
			end
		endcase
		// Pin low forces reset from any state; latched straps kept until next hold end
		if (!por_level) begin
			next_state = strap_cfg_pkg::ST_RESET;
			next_load_issued = 1'b0;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			state <= strap_cfg_pkg::ST_RESET;
			hold_cnt <= 32'h0000_0000;
			load_addr <= 8'h00_00;
			load_issued <= 1'b0;
			otp_custom <= 1'b0;
			otp_addr_out <= 8'h00_00;
			mclk_sel_out <= 2'h0;
			strap_opts_out <= 3'h0;
		end else begin
			state <= next_state;
			hold_cnt <= next_hold_cnt;
			load_addr <= next_load_addr;
			load_issued <= next_load_issued;
			otp_custom <= next_otp_custom;
			otp_addr_out <= next_otp_addr;
			mclk_sel_out <= next_mclk_sel;
			strap_opts_out <= next_strap_opts;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Host answers and device outputs

	logic running;
	logic next_host_ack;
	logic [7:0] next_host_rdata;
	logic next_mclk_ok;
	logic [5:0] next_gpio_out;
	logic [5:0] next_gpio_oe;
	logic next_ref_zero;
	logic next_ref_one;
	logic [3:0] next_diff_en;
	logic [1:0] next_cmos_en;

	assign running = (next_state == strap_cfg_pkg::ST_RUN);

	always_comb begin
		next_host_ack = 1'b0;
		next_host_rdata = host_rdata_out;
		if (state == strap_cfg_pkg::ST_RUN && por_level && host_req_in) begin
			next_host_ack = 1'b1;
			if (host_addr_in == strap_cfg_pkg::STATUS_ADDR) begin
				next_host_rdata = status_val;
			end else if (host_addr_in <= strap_cfg_pkg::CFG_LAST_ADDR) begin
				next_host_rdata = cfg_mem[host_addr_in];
			end else begin
				next_host_rdata = 8'h00_00;
			end
		end
		next_mclk_ok = (next_mclk_sel == strap_cfg_pkg::MCLK_24M576);
		next_gpio_out = 6'h00;
		next_gpio_oe = 6'h00;
		next_ref_zero = strap_cfg_pkg::REF_TYPE_RESET[strap_cfg_pkg::REF_ZERO_DIFF_BIT];
		next_ref_one = strap_cfg_pkg::REF_TYPE_RESET[strap_cfg_pkg::REF_ONE_DIFF_BIT];
		next_diff_en = 4'h0;
		next_cmos_en = 2'h0;
		if (running) begin
			next_gpio_out = cfg_mem[strap_cfg_pkg::GPIO_OUT_ADDR][5:0];
			next_gpio_oe = cfg_mem[strap_cfg_pkg::GPIO_OE_ADDR][5:0];
			next_ref_zero = cfg_mem[strap_cfg_pkg::REF_TYPE_ADDR][strap_cfg_pkg::REF_ZERO_DIFF_BIT];
			next_ref_one = cfg_mem[strap_cfg_pkg::REF_TYPE_ADDR][strap_cfg_pkg::REF_ONE_DIFF_BIT];
			next_diff_en = cfg_mem[strap_cfg_pkg::DIFF_EN_ADDR][3:0];
			next_cmos_en = cfg_mem[strap_cfg_pkg::CMOS_EN_ADDR][1:0];
			// Test strap only counts while the pin is not driven by us
			next_diff_en[0] = next_diff_en[0] | (gpio_level[strap_cfg_pkg::TEST_STRAP_BIT]
				& ~next_gpio_oe[strap_cfg_pkg::TEST_STRAP_BIT]);
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			host_ack_out <= 1'b0;
			host_rdata_out <= 8'h00_00;
			host_busy_out <= 1'b1;
			device_rst_out <= 1'b1;
			config_done_out <= 1'b0;
			mclk_24m576_out <= 1'b0;
			mclk_reserved_out <= 1'b1;
			gpio_out <= 6'h00;
			gpio_oe_out <= 6'h00;
			ref_zero_diff_out <= 1'b1;
			ref_one_diff_out <= 1'b0;
			diff_out_en_out <= 4'h0;
			cmos_out_en_out <= 2'h0;
		end else begin
			host_ack_out <= next_host_ack;
			host_rdata_out <= next_host_rdata;
			host_busy_out <= ~running;
			device_rst_out <= ~running;
			config_done_out <= running;
			mclk_24m576_out <= next_mclk_ok;
			mclk_reserved_out <= ~next_mclk_ok;
			gpio_out <= next_gpio_out;
			gpio_oe_out <= next_gpio_oe;
			ref_zero_diff_out <= next_ref_zero;
			ref_one_diff_out <= next_ref_one;
			diff_out_en_out <= next_diff_en;
			cmos_out_en_out <= next_cmos_en;
		end
	end

endmodule

// [verification/strap_loader_chk.sv]
// Port assertions for the strap and configuration loader
`timescale 1ns/100ps
module strap_loader_chk #(
	parameter int HOLD_CYCLES = 20
) (
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic sys_rst_in,
	// Watched ports
	input wire logic host_req_in,
	input wire logic otp_custom_in,
	input wire logic [7:0] otp_addr_out,
	input wire logic host_ack_out,
	input wire logic host_busy_out,
	input wire logic device_rst_out,
	input wire logic config_done_out,
	input wire logic [1:0] mclk_sel_out,
	input wire logic mclk_24m576_out,
	input wire logic mclk_reserved_out,
	input wire logic [2:0] strap_opts_out,
	input wire logic ref_zero_diff_out,
	input wire logic ref_one_diff_out,
	input wire logic [3:0] diff_out_en_out,
	input wire logic [1:0] cmos_out_en_out,
	input wire logic [5:0] gpio_oe_out
);
	default clocking @(posedge sys_clk_in);
	endclocking
	default disable iff (sys_rst_in);
	////////////////////////////////////////////////////////////////////////////////
	chk_host_answer: assert property (host_req_in && !host_busy_out |=> host_ack_out)
		else $error("host request not answered");
	chk_busy_refuse: assert property (host_busy_out |=> !host_ack_out)
		else $error("request answered while loading");
	chk_idle_outputs: assert property (device_rst_out && $past(device_rst_out) |->
		diff_out_en_out == 4'h0 && cmos_out_en_out == 2'h0 && gpio_oe_out == 6'h00)
		else $error("output enabled while not running");
	chk_ref_idle: assert property (device_rst_out && $past(device_rst_out) |->
		ref_zero_diff_out && !ref_one_diff_out)
		else $error("reference types not at default");
	chk_mclk_decode: assert property (mclk_24m576_out == (mclk_sel_out == 2'h3)
		&& mclk_reserved_out != mclk_24m576_out)
		else $error("master clock decode wrong");
	chk_strap_frozen: assert property (!device_rst_out && !$past(device_rst_out) |->
		$stable(mclk_sel_out) && $stable(strap_opts_out))
		else $error("latched straps changed while running");
	chk_otp_step: assert property (host_busy_out && otp_addr_out != 8'h00
		&& otp_addr_out < 8'hFC |=> otp_addr_out == $past(otp_addr_out) + 8'h01)
		else $error("image address did not step");
	chk_load_end: assert property (host_busy_out && otp_addr_out == 8'hFC
		&& $past(otp_addr_out) == 8'hFB |-> ##[1:3] !host_busy_out)
		else $error("load did not end after last address");
	chk_done_level: assert property (config_done_out != device_rst_out)
		else $error("done and device reset agree");
	cover property (host_req_in && !host_busy_out ##1 host_ack_out);
	cover property (otp_custom_in && otp_addr_out == 8'hFC);
	cover property ($fell(host_busy_out) && mclk_24m576_out);
endmodule

// [verification/board_partner.sv]
// Board model: reset circuit, strap pins and stored image
`timescale 1ns/100ps
module board_partner #(
	parameter int HOLD = 20,
	parameter int RST_LOW = 8
) (
	// Clock and supply status
	input wire logic clk_in,
	input wire logic power_good_in,
	// Strap levels to present
	input wire logic [5:0] strap_in,
	input wire logic test_strap_in,
	// Image port, reset pin and pin levels
	input wire logic [7:0] otp_addr_in,
	output logic power_on_rst_n_out,
	output logic [5:0] gpio_out,
	output logic [7:0] otp_data_out
);
	int cnt = 0;
	logic hold;
	always @(posedge clk_in) begin
		if (!power_good_in)
			cnt <= 0;
		else if (cnt < 1000)
			cnt <= cnt + 1;
	end
	assign power_on_rst_n_out = cnt >= RST_LOW;
	// Straps held through the window, then released to changing levels
	assign hold = cnt < RST_LOW + HOLD + 10;
	assign gpio_out[1:0] = hold ? strap_in[1:0] : ~strap_in[1:0];
	assign gpio_out[5:3] = hold ? strap_in[5:3] : ~strap_in[5:3];
	assign gpio_out[2] = test_strap_in;
	assign otp_data_out = otp_addr_in ^ 8'hA5;
endmodule

// [verification/powerup_strap_config_loader_tb_top.sv]
// Testbench for the power-up strap and configuration loader
`timescale 1ns/100ps
module powerup_strap_config_loader_tb_top;
	localparam int HOLD = 20;
	logic sys_clk_in = 0, sys_rst_in = 1, power_on_rst_n_in, otp_custom_in = 0;
	logic host_req_in = 0, host_we_in = 0, host_ack_out, host_busy_out, device_rst_out;
	logic config_done_out, mclk_24m576_out, mclk_reserved_out, ref_zero_diff_out;
	logic ref_one_diff_out, pg = 0, test_strap = 0;
	logic [5:0] gpio_in, gpio_out, gpio_oe_out, board_gpio, strap = 6'h00;
	logic [7:0] otp_data_in, otp_addr_out, host_addr_in = 8'h00, host_wdata_in = 8'h00;
	logic [7:0] host_rdata_out, rd;
	logic [1:0] mclk_sel_out, cmos_out_en_out;
	logic [2:0] strap_opts_out;
	logic [3:0] diff_out_en_out;
	int err_total = 0, num_checks = 0;
	////////////////////////////////////////////////////////////////////////////////
	powerup_strap_config_loader #(.HOLD_CYCLES(HOLD)) i_powerup_strap_config_loader (
		.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
		.power_on_rst_n_in(power_on_rst_n_in),
		.gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe_out(gpio_oe_out),
		.otp_custom_in(otp_custom_in), .otp_data_in(otp_data_in), .otp_addr_out(otp_addr_out),
		.host_req_in(host_req_in), .host_we_in(host_we_in), .host_addr_in(host_addr_in),
		.host_wdata_in(host_wdata_in), .host_ack_out(host_ack_out),
		.host_rdata_out(host_rdata_out), .host_busy_out(host_busy_out),
		.device_rst_out(device_rst_out), .config_done_out(config_done_out),
		.mclk_sel_out(mclk_sel_out), .mclk_24m576_out(mclk_24m576_out),
		.mclk_reserved_out(mclk_reserved_out), .strap_opts_out(strap_opts_out),
		.ref_zero_diff_out(ref_zero_diff_out), .ref_one_diff_out(ref_one_diff_out),
		.diff_out_en_out(diff_out_en_out), .cmos_out_en_out(cmos_out_en_out));
	board_partner #(.HOLD(HOLD)) i_board_partner (.clk_in(sys_clk_in), .power_good_in(pg),
		.strap_in(strap), .test_strap_in(test_strap), .otp_addr_in(otp_addr_out),
		.power_on_rst_n_out(power_on_rst_n_in), .gpio_out(board_gpio),
		.otp_data_out(otp_data_in));
	assign gpio_in = (gpio_oe_out & gpio_out) | (~gpio_oe_out & board_gpio);
	initial begin
		forever #5 sys_clk_in = ~sys_clk_in;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic print_verdict();
		if (err_total == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic host(input logic we, input logic [7:0] a, input logic [7:0] d,
		input logic ok);
		@(posedge sys_clk_in);
		#1;
		host_req_in = 1;
		host_we_in = we;
		host_addr_in = a;
		host_wdata_in = d;
		@(posedge sys_clk_in);
		#1;
		host_req_in = 0;
		chk("ack", 8'(ok), 8'(host_ack_out));
		rd = host_rdata_out;
	endtask
	task automatic rdchk(input string name, input logic [7:0] a, input logic [7:0] exp);
		host(1'b0, a, 8'h00, 1'b1);
		chk(name, exp, rd);
	endtask
	task automatic power_up(input logic [5:0] s, input logic c);
		int n;
		pg = 0;
		strap = s;
		otp_custom_in = c;
		repeat (3) @(posedge sys_clk_in);
		#1;
		pg = 1;
		repeat (6) @(posedge sys_clk_in);
		host(1'b1, 8'h20, 8'hFF, 1'b0);
		for (n = 0; n < 1000 && host_busy_out !== 1'b0; n++) begin
			@(posedge sys_clk_in);
			#1;
		end
		if (host_busy_out !== 1'b0) begin
			err_total++;
			print_verdict();
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_defaults();
		power_up(6'h03, 1'b0);
		chk("mclk_sel", 8'h03, 8'(mclk_sel_out));
		chk("mclk_24m576", 8'h01, 8'(mclk_24m576_out));
		chk("ref_types", 8'h01, 8'({ref_one_diff_out, ref_zero_diff_out}));
		chk("enables", 8'h00, 8'({diff_out_en_out, cmos_out_en_out}));
		chk("run_flags", 8'h02, 8'({config_done_out, device_rst_out}));
		rdchk("ref_reg", 8'h0A, 8'h01);
		rdchk("diff_reg", 8'h20, 8'h00);
		rdchk("status", 8'h40, 8'hC3);
	endtask
	task automatic t_host();
		host(1'b1, 8'h20, 8'h0F, 1'b1);
		host(1'b1, 8'h21, 8'h03, 1'b1);
		host(1'b1, 8'h0A, 8'h02, 1'b1);
		@(posedge sys_clk_in);
		#1;
		chk("enables", 8'h3F, 8'({diff_out_en_out, cmos_out_en_out}));
		chk("ref_types", 8'h02, 8'({ref_one_diff_out, ref_zero_diff_out}));
		host(1'b1, 8'h40, 8'h00, 1'b1);
		rdchk("status_ro", 8'h40, 8'hC3);
		host(1'b1, 8'hFC, 8'h5A, 1'b1);
		rdchk("last_reg", 8'hFC, 8'h5A);
		rdchk("beyond", 8'hFD, 8'h00);
	endtask
	task automatic t_test_strap();
		host(1'b1, 8'h20, 8'h00, 1'b1);
		test_strap = 1;
		repeat (8) @(posedge sys_clk_in);
		#1;
		chk("test_strap", 8'h01, 8'(diff_out_en_out));
		test_strap = 0;
	endtask
	task automatic t_otp();
		power_up(6'h29, 1'b1);
		chk("mclk_reserved", 8'h01, 8'(mclk_reserved_out));
		chk("opts", 8'h05, 8'(strap_opts_out));
		chk("ref_types", 8'h03, 8'({ref_one_diff_out, ref_zero_diff_out}));
		chk("diff_en", 8'h05, 8'(diff_out_en_out));
		chk("gpio_oe", 8'h14, 8'(gpio_oe_out));
		chk("gpio_out", 8'h15, 8'(gpio_out));
		rdchk("status", 8'h40, 8'hB5);
		rdchk("otp_last", 8'hFC, 8'h59);
	endtask
	initial begin
		repeat (6) @(posedge sys_clk_in);
		#1;
		sys_rst_in = 0;
		t_defaults();
		t_host();
		t_test_strap();
		t_otp();
		print_verdict();
	end
endmodule
bind powerup_strap_config_loader strap_loader_chk #(.HOLD_CYCLES(HOLD_CYCLES))
	i_strap_loader_chk (
	.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .host_req_in(host_req_in),
	.otp_custom_in(otp_custom_in), .otp_addr_out(otp_addr_out), .host_ack_out(host_ack_out),
	.host_busy_out(host_busy_out), .device_rst_out(device_rst_out),
	.config_done_out(config_done_out),
	.mclk_sel_out(mclk_sel_out), .mclk_24m576_out(mclk_24m576_out),
	.mclk_reserved_out(mclk_reserved_out), .strap_opts_out(strap_opts_out),
	.ref_zero_diff_out(ref_zero_diff_out), .ref_one_diff_out(ref_one_diff_out),
	.diff_out_en_out(diff_out_en_out), .cmos_out_en_out(cmos_out_en_out),
	.gpio_oe_out(gpio_oe_out));
